//--- logic/rbt_defines.svh
// Constants of the registered bus transceiver
`ifndef RBT_DEFINES_SVH
`define RBT_DEFINES_SVH

`define RBT_HALF_W 8
`define RBT_HALVES 2
`define RBT_BUS_W 16
`define RBT_CTL_W 6
`define RBT_SYNC_W 44
// Idle synchroniser state: B-to-A drive off, capture clocks high
`define RBT_SYNC_RESET 44'h000000003f0

`define RBT_ADDR_W 4
`define RBT_OFS_CTRL 4'h0
`define RBT_OFS_A_STORE 4'h4
`define RBT_OFS_B_STORE 4'h8
`define RBT_OFS_PIN_STAT 4'hc

`define RBT_CTRL_GANG_BIT 0
`define RBT_CTRL_RESET 1'h0
`define RBT_DATA_RESET 8'h00

`define RBT_RESP_OKAY 2'h0
`define RBT_RESP_SLVERR 2'h2

`endif

//--- logic/rbt_pkg.sv
// Types of the registered bus transceiver
`include "rbt_defines.svh"

package rbt_pkg;
  typedef logic [`RBT_HALF_W-1:0] rbt_half_type;
  typedef logic [`RBT_BUS_W-1:0] rbt_bus_type;
  typedef logic [1:0] rbt_resp_type;
  typedef enum logic {RBT_WR_COLLECT, RBT_WR_RESPOND} rbt_wr_state_type;
endpackage : rbt_pkg

//--- logic/rbt_half.sv
// One 8-bit half: capture registers, source selection, drivers and keeper
`timescale 1ns/1ns
`include "rbt_defines.svh"

module rbt_half
  import rbt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Synchronised port levels
  input wire rbt_half_type a_live_i,
  input wire rbt_half_type b_live_i,
  // Synchronised controls
  input wire logic a_to_b_drive_en_i,
  input wire logic b_to_a_drive_en_n_i,
  input wire logic a_capture_clk_i,
  input wire logic b_capture_clk_i,
  input wire logic b_port_source_sel_i,
  input wire logic a_port_source_sel_i,
  // Port drivers, enables low while driving
  output rbt_half_type a_out_o,
  output logic a_oe_n_o,
  output rbt_half_type b_out_o,
  output logic b_oe_n_o,
  // Keeper levels and stored data
  output rbt_half_type a_keep_o,
  output rbt_half_type b_keep_o,
  output rbt_half_type a_store_o,
  output rbt_half_type b_store_o
);

  logic a_clk_prev_reg;
  logic b_clk_prev_reg;
  rbt_half_type a_store_reg;
  rbt_half_type b_store_reg;
  rbt_half_type a_out_reg;
  rbt_half_type b_out_reg;
  logic a_oe_n_reg;
  logic b_oe_n_reg;
  rbt_half_type a_keep_reg;
  rbt_half_type b_keep_reg;

  wire a_rise = a_capture_clk_i & ~a_clk_prev_reg;
  wire b_rise = b_capture_clk_i & ~b_clk_prev_reg;
  wire drive_b = a_to_b_drive_en_i;
  wire drive_a = ~b_to_a_drive_en_n_i;
  // Live opposite port when select low, stored data when high
  wire rbt_half_type b_out_next = b_port_source_sel_i ? a_store_reg : a_live_i;
  wire rbt_half_type a_out_next = a_port_source_sel_i ? b_store_reg : b_live_i;
  // A driven port presents what the device drives onto it
  wire rbt_half_type a_cap_data = drive_a ? a_out_next : a_live_i;
  wire rbt_half_type b_cap_data = drive_b ? b_out_next : b_live_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_clk_prev_reg <= 1'b1;
      b_clk_prev_reg <= 1'b1;
      a_store_reg <= `RBT_DATA_RESET;
      b_store_reg <= `RBT_DATA_RESET;
    end else begin
      a_clk_prev_reg <= a_capture_clk_i;
      b_clk_prev_reg <= b_capture_clk_i;
      if (a_rise) begin
        a_store_reg <= a_cap_data;
      end
      if (b_rise) begin
        b_store_reg <= b_cap_data;
      end
    end
  end

  // Registered outputs switch cleanly between sources
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      a_out_reg <= `RBT_DATA_RESET;
      b_out_reg <= `RBT_DATA_RESET;
      a_oe_n_reg <= 1'b1;
      b_oe_n_reg <= 1'b1;
      a_keep_reg <= `RBT_DATA_RESET;
      b_keep_reg <= `RBT_DATA_RESET;
    end else begin
      a_out_reg <= a_out_next;
      b_out_reg <= b_out_next;
      a_oe_n_reg <= ~drive_a;
      b_oe_n_reg <= ~drive_b;
      a_keep_reg <= a_cap_data;
      b_keep_reg <= b_cap_data;
    end
  end

  assign a_out_o = a_out_reg;
  assign b_out_o = b_out_reg;
  assign a_oe_n_o = a_oe_n_reg;
  assign b_oe_n_o = b_oe_n_reg;
  assign a_keep_o = a_keep_reg;
  assign b_keep_o = b_keep_reg;
  assign a_store_o = a_store_reg;
  assign b_store_o = b_store_reg;

endmodule : rbt_half

//--- logic/rbt_top.sv
// Registered bus transceiver top: pin synchronisers, two halves, AXI4-Lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "rbt_defines.svh"

// Function
// - Each capture clock rising edge stores its own port, regardless of selects and enables.
// - Source select low passes live opposite port; high passes stored register contents.
// - Changing a source select never shows a wrong transient value on outputs.
// - Works as one 16-bit or two 8-bit halves with separate controls.
// - Both enables high, B select low: B port follows live A.
// - Both enables low, A select low: A port follows live B.
// - Both enables low, A select high: A port shows B register.
// - Both directions enabled, both selects high: each port shows opposite register.
// - B port echoing A: both capture edges store A data in both registers.
// - A port echoing B: both capture edges store B data in both registers.
// - Both live, both directions enabled: outputs reinforce inputs, buses keep levels.
// - Undriven data inputs are held at their last valid level.
module rbt_top
  import rbt_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // A port pins
  input wire rbt_bus_type a_in_i,
  output rbt_bus_type a_out_o,
  output logic [`RBT_HALVES-1:0] a_oe_n_o,
  output rbt_bus_type a_keep_o,
  // B port pins
  input wire rbt_bus_type b_in_i,
  output rbt_bus_type b_out_o,
  output logic [`RBT_HALVES-1:0] b_oe_n_o,
  output rbt_bus_type b_keep_o,
  // Control pins, one bit per half
  input wire logic [`RBT_HALVES-1:0] a_to_b_drive_en_i,
  input wire logic [`RBT_HALVES-1:0] b_to_a_drive_en_n_i,
  input wire logic [`RBT_HALVES-1:0] a_capture_clk_i,
  input wire logic [`RBT_HALVES-1:0] b_capture_clk_i,
  input wire logic [`RBT_HALVES-1:0] b_port_source_sel_i,
  input wire logic [`RBT_HALVES-1:0] a_port_source_sel_i,
  // AXI4-Lite write address
  input wire logic [`RBT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`RBT_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Pin synchronisers
  logic [`RBT_SYNC_W-1:0] sync1_reg;
  logic [`RBT_SYNC_W-1:0] sync2_reg;

  wire [`RBT_SYNC_W-1:0] pins_raw = {
    a_in_i,
    b_in_i,
    a_to_b_drive_en_i,
    b_to_a_drive_en_n_i,
    a_capture_clk_i,
    b_capture_clk_i,
    b_port_source_sel_i,
    a_port_source_sel_i
  };

  // Reset state keeps ports undriven and hides a clock held high at release
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= `RBT_SYNC_RESET;
      sync2_reg <= `RBT_SYNC_RESET;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire rbt_bus_type a_live = sync2_reg[43:28];
  wire rbt_bus_type b_live = sync2_reg[27:12];
  wire [`RBT_HALVES-1:0] ab_en_s = sync2_reg[11:10];
  wire [`RBT_HALVES-1:0] ba_en_n_s = sync2_reg[9:8];
  wire [`RBT_HALVES-1:0] a_clk_s = sync2_reg[7:6];
  wire [`RBT_HALVES-1:0] b_clk_s = sync2_reg[5:4];
  wire [`RBT_HALVES-1:0] b_sel_s = sync2_reg[3:2];
  wire [`RBT_HALVES-1:0] a_sel_s = sync2_reg[1:0];

  // Control register
  logic gang_reg;

  // Half outputs
  rbt_bus_type a_store;
  rbt_bus_type b_store;

  // Two halves; gang mode lets half 0 controls steer both
  genvar h;
  generate
    for (h = 0; h < `RBT_HALVES; h = h + 1) begin : g_half
      wire use_zero = gang_reg && (h != 0);
      wire ab_en = use_zero ? ab_en_s[0] : ab_en_s[h];
      wire ba_en_n = use_zero ? ba_en_n_s[0] : ba_en_n_s[h];
      wire a_clk = use_zero ? a_clk_s[0] : a_clk_s[h];
      wire b_clk = use_zero ? b_clk_s[0] : b_clk_s[h];
      wire b_sel = use_zero ? b_sel_s[0] : b_sel_s[h];
      wire a_sel = use_zero ? a_sel_s[0] : a_sel_s[h];

      rbt_half u_half (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .a_live_i(a_live[h*`RBT_HALF_W +: `RBT_HALF_W]),
        .b_live_i(b_live[h*`RBT_HALF_W +: `RBT_HALF_W]),
        .a_to_b_drive_en_i(ab_en),
        .b_to_a_drive_en_n_i(ba_en_n),
        .a_capture_clk_i(a_clk),
        .b_capture_clk_i(b_clk),
        .b_port_source_sel_i(b_sel),
        .a_port_source_sel_i(a_sel),
        .a_out_o(a_out_o[h*`RBT_HALF_W +: `RBT_HALF_W]),
        .a_oe_n_o(a_oe_n_o[h]),
        .b_out_o(b_out_o[h*`RBT_HALF_W +: `RBT_HALF_W]),
        .b_oe_n_o(b_oe_n_o[h]),
        .a_keep_o(a_keep_o[h*`RBT_HALF_W +: `RBT_HALF_W]),
        .b_keep_o(b_keep_o[h*`RBT_HALF_W +: `RBT_HALF_W]),
        .a_store_o(a_store[h*`RBT_HALF_W +: `RBT_HALF_W]),
        .b_store_o(b_store[h*`RBT_HALF_W +: `RBT_HALF_W])
      );
    end
  endgenerate

  // Write channel: address and data taken in either order
  rbt_wr_state_type wr_state_reg;
  rbt_wr_state_type wr_state_next;
  logic aw_held_reg;
  logic w_held_reg;
  logic [`RBT_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg;

  wire collecting = (wr_state_reg == RBT_WR_COLLECT);
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_reg || aw_fire;
  wire w_have = w_held_reg || w_fire;
  wire wr_go = collecting && aw_have && w_have;
  wire [`RBT_ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_ctrl = (wr_addr == `RBT_OFS_CTRL);
  wire wr_ro = (wr_addr == `RBT_OFS_A_STORE) || (wr_addr == `RBT_OFS_B_STORE) || (wr_addr == `RBT_OFS_PIN_STAT);
  wire rbt_resp_type wr_resp = (wr_ctrl || wr_ro) ? `RBT_RESP_OKAY : `RBT_RESP_SLVERR;

  assign s_axi_awready = collecting && !aw_held_reg;
  assign s_axi_wready = collecting && !w_held_reg;
  assign s_axi_bvalid = (wr_state_reg == RBT_WR_RESPOND);
  assign s_axi_bresp = bresp_reg;

  always_comb begin
    wr_state_next = wr_state_reg;
    unique case (wr_state_reg)
      RBT_WR_COLLECT: begin
        if (wr_go) begin
          wr_state_next = RBT_WR_RESPOND;
        end
      end
      RBT_WR_RESPOND: begin
        if (s_axi_bready) begin
          wr_state_next = RBT_WR_COLLECT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_state_reg <= RBT_WR_COLLECT;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bresp_reg <= `RBT_RESP_OKAY;
    end else begin
      wr_state_reg <= wr_state_next;
      if (aw_fire) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      aw_held_reg <= wr_go ? 1'b0 : aw_have;
      w_held_reg <= wr_go ? 1'b0 : w_have;
      if (wr_go) begin
        bresp_reg <= wr_resp;
      end
    end
  end

  // Control register write, lowest byte lane only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gang_reg <= `RBT_CTRL_RESET;
    end else if (wr_go && wr_ctrl && wr_strb[0]) begin
      gang_reg <= wr_data[`RBT_CTRL_GANG_BIT];
    end
  end

  // Read channel
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire [31:0] pin_stat = {
    20'h00000,
    a_sel_s,
    b_sel_s,
    b_clk_s,
    a_clk_s,
    ba_en_n_s,
    ab_en_s
  };
  wire rd_ctrl = (s_axi_araddr == `RBT_OFS_CTRL);
  wire rd_a = (s_axi_araddr == `RBT_OFS_A_STORE);
  wire rd_b = (s_axi_araddr == `RBT_OFS_B_STORE);
  wire rd_pin = (s_axi_araddr == `RBT_OFS_PIN_STAT);
  wire rd_hit = rd_ctrl || rd_a || rd_b || rd_pin;
  wire [31:0] rd_data =
    rd_ctrl ? {31'h00000000, gang_reg} :
    rd_a ? {16'h0000, a_store} :
    rd_b ? {16'h0000, b_store} :
    rd_pin ? pin_stat : 32'h00000000;
  wire rbt_resp_type rd_resp = rd_hit ? `RBT_RESP_OKAY : `RBT_RESP_SLVERR;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RBT_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : rbt_top

//--- bench/rbt_bus_model.sv
// Far-side bus model: resolves both buses per half
`timescale 1ns/1ns
`include "rbt_defines.svh"
module rbt_bus_model
  import rbt_pkg::*;
(
  // Device side
  input wire rbt_bus_type a_out_i,
  input wire logic [1:0] a_oe_n_i,
  input wire rbt_bus_type a_keep_i,
  input wire rbt_bus_type b_out_i,
  input wire logic [1:0] b_oe_n_i,
  input wire rbt_bus_type b_keep_i,
  // Other drivers
  input wire rbt_bus_type a_drv_i,
  input wire logic [1:0] a_drv_en_i,
  input wire rbt_bus_type b_drv_i,
  input wire logic [1:0] b_drv_en_i,
  // Resolved levels
  output rbt_bus_type a_bus_o,
  output rbt_bus_type b_bus_o
);
  // Device, else other driver, else bus hold
  for (genvar h = 0; h < `RBT_HALVES; h++) begin : g_half
    assign a_bus_o[h*8+:8] = !a_oe_n_i[h] ? a_out_i[h*8+:8] : a_drv_en_i[h] ? a_drv_i[h*8+:8] : a_keep_i[h*8+:8];
    assign b_bus_o[h*8+:8] = !b_oe_n_i[h] ? b_out_i[h*8+:8] : b_drv_en_i[h] ? b_drv_i[h*8+:8] : b_keep_i[h*8+:8];
  end
endmodule : rbt_bus_model

//--- bench/rbt_monitor.sv
// Port checker for the transceiver
`timescale 1ns/1ns
`include "rbt_defines.svh"
module rbt_monitor
  import rbt_pkg::*;
(
  // Clock, reset, pins
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire rbt_bus_type a_in_i,
  input wire rbt_bus_type a_out_o,
  input wire logic [1:0] a_oe_n_o,
  input wire rbt_bus_type a_keep_o,
  input wire rbt_bus_type b_in_i,
  input wire rbt_bus_type b_out_o,
  input wire logic [1:0] b_oe_n_o,
  // Controls
  input wire logic [1:0] a_to_b_drive_en_i,
  input wire logic [1:0] b_to_a_drive_en_n_i,
  input wire logic [1:0] a_capture_clk_i,
  input wire logic [1:0] b_capture_clk_i,
  input wire logic [1:0] b_port_source_sel_i,
  input wire logic [1:0] a_port_source_sel_i
);
  logic [`RBT_SYNC_W-1:0] ins_reg;
  logic [2:0] pin_cnt_reg;
  logic [2:0] ctl_cnt_reg;
  wire [`RBT_SYNC_W-1:0] ins = {a_in_i, b_in_i, a_to_b_drive_en_i, b_to_a_drive_en_n_i, a_capture_clk_i,
    b_capture_clk_i, b_port_source_sel_i, a_port_source_sel_i};
  wire steady = pin_cnt_reg >= 3'h6 && ins == ins_reg;
  wire ctl_steady = ctl_cnt_reg >= 3'h6 && ins[11:0] == ins_reg[11:0];
  // Cycles since pins or controls last moved
  always_ff @(posedge clk_i) begin
    ins_reg <= ins;
    pin_cnt_reg <= (!rst_n_i || ins != ins_reg) ? 3'h0 : pin_cnt_reg + {2'h0, pin_cnt_reg != 3'h7};
    ctl_cnt_reg <= (!rst_n_i || ins[11:0] != ins_reg[11:0]) ? 3'h0 : ctl_cnt_reg + {2'h0, ctl_cnt_reg != 3'h7};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  iso_ports_a: assert property (steady && !a_to_b_drive_en_i[0] && b_to_a_drive_en_n_i[0]
    |-> a_oe_n_o[0] && b_oe_n_o[0]) else $error("port driven in isolation");
  live_to_b_a: assert property (steady && a_to_b_drive_en_i[0] && !b_port_source_sel_i[0]
    |-> !b_oe_n_o[0] && b_out_o[7:0] == a_in_i[7:0]) else $error("B not live A");
  live_to_a_a: assert property (steady && !b_to_a_drive_en_n_i[0] && !a_port_source_sel_i[0]
    |-> !a_oe_n_o[0] && a_out_o[7:0] == b_in_i[7:0]) else $error("A not live B");
  upper_live_a: assert property (steady && a_to_b_drive_en_i == 2'h3 && b_port_source_sel_i == 2'h0
    |-> b_out_o[15:8] == a_in_i[15:8]) else $error("upper half not live");
  loop_match_a: assert property (steady && a_to_b_drive_en_i[0] && !b_to_a_drive_en_n_i[0]
    && !b_port_source_sel_i[0] && !a_port_source_sel_i[0] |-> a_in_i[7:0] == b_in_i[7:0]) else $error("loop split");
  keep_level_a: assert property (steady && a_oe_n_o[0] |-> a_keep_o[7:0] == a_in_i[7:0])
    else $error("keeper wrong");
  held_a_out_a: assert property (ctl_steady && a_port_source_sel_i[0] && !b_to_a_drive_en_n_i[0]
    |=> $stable(a_out_o[7:0])) else $error("stored A moved");
  held_b_out_a: assert property (ctl_steady && b_port_source_sel_i[0] && a_to_b_drive_en_i[0]
    |=> $stable(b_out_o[7:0])) else $error("stored B moved");
  cover property (steady && !a_oe_n_o[0] && !b_oe_n_o[0]);
  cover property (ctl_steady && a_port_source_sel_i[0] && !a_oe_n_o[0]);
  cover property (steady && a_oe_n_o == 2'h3 && b_oe_n_o == 2'h3);
endmodule : rbt_monitor
bind rbt_top rbt_monitor rbt_monitor_inst (.clk_i, .rst_n_i, .a_in_i, .a_out_o, .a_oe_n_o, .a_keep_o, .b_in_i,
  .b_out_o, .b_oe_n_o, .a_to_b_drive_en_i, .b_to_a_drive_en_n_i, .a_capture_clk_i, .b_capture_clk_i,
  .b_port_source_sel_i, .a_port_source_sel_i);

//--- bench/tb_registered_bus_transceiver.sv
// Self-checking bench for the transceiver
`timescale 1ns/1ns
`include "rbt_defines.svh"
module tb_registered_bus_transceiver
  import rbt_pkg::*;
;
  logic clk_i, rst_n_i;
  rbt_bus_type a_in_i, a_out_o, a_keep_o, b_in_i, b_out_o, b_keep_o, a_drv, b_drv;
  logic [1:0] a_oe_n_o, b_oe_n_o, a_den, b_den, a_to_b_drive_en_i, b_to_a_drive_en_n_i, a_capture_clk_i,
    b_capture_clk_i, b_port_source_sel_i, a_port_source_sel_i, s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    s_axi_arready, s_axi_rvalid, s_axi_rready;
  int bad_count, n_compared, cyc;
  rbt_top rbt_top_inst (.clk_i, .rst_n_i, .a_in_i, .a_out_o, .a_oe_n_o, .a_keep_o, .b_in_i, .b_out_o, .b_oe_n_o,
    .b_keep_o, .a_to_b_drive_en_i, .b_to_a_drive_en_n_i, .a_capture_clk_i, .b_capture_clk_i, .b_port_source_sel_i,
    .a_port_source_sel_i, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rbt_bus_model rbt_bus_model_inst (.a_out_i(a_out_o), .a_oe_n_i(a_oe_n_o), .a_keep_i(a_keep_o), .b_out_i(b_out_o),
    .b_oe_n_i(b_oe_n_o), .b_keep_i(b_keep_o), .a_drv_i(a_drv), .a_drv_en_i(a_den), .b_drv_i(b_drv),
    .b_drv_en_i(b_den), .a_bus_o(a_in_i), .b_bus_o(b_in_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end
  task close_out;
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task setup(input logic [1:0] ab, ba, bs, as, ae, be, input rbt_bus_type av, bv);
    @(posedge clk_i);
    a_to_b_drive_en_i <= ab;
    b_to_a_drive_en_n_i <= ba;
    b_port_source_sel_i <= bs;
    a_port_source_sel_i <= as;
    a_den <= ae;
    b_den <= be;
    a_drv <= av;
    b_drv <= bv;
    repeat (8) @(posedge clk_i);
  endtask : setup
  task pulse(input logic [1:0] am, bm);
    @(posedge clk_i);
    a_capture_clk_i <= am;
    b_capture_clk_i <= bm;
    repeat (3) @(posedge clk_i);
    a_capture_clk_i <= 2'h0;
    b_capture_clk_i <= 2'h0;
    repeat (8) @(posedge clk_i);
  endtask : pulse
  task wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr
  task rd(input logic [3:0] ad, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : rd
  task t_reset;
    chk("oe_n", 32'({a_oe_n_o, b_oe_n_o}), 32'hf);
    rd(4'h0, 32'h0, `RBT_RESP_OKAY);
    rd(4'h4, 32'h0, `RBT_RESP_OKAY);
    rd(4'h8, 32'h0, `RBT_RESP_OKAY);
  endtask : t_reset
  task t_isolate;
    setup(2'h0, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 16'h5aa5, 16'h3cc3);
    chk("oe_n", 32'({a_oe_n_o, b_oe_n_o}), 32'hf);
    pulse(2'h3, 2'h3);
    rd(4'h4, 32'h5aa5, `RBT_RESP_OKAY);
    rd(4'h8, 32'h3cc3, `RBT_RESP_OKAY);
  endtask : t_isolate
  task t_fwd;
    setup(2'h1, 2'h3, 2'h0, 2'h0, 2'h3, 2'h2, 16'h1234, 16'hab00);
    chk("b_half", 32'(b_in_i), 32'hab34);
    setup(2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h0, 16'h1234, 16'h0);
    pulse(2'h3, 2'h3);
    rd(4'h4, 32'h1234, `RBT_RESP_OKAY);
    rd(4'h8, 32'h1234, `RBT_RESP_OKAY);
    b_port_source_sel_i <= 2'h3;
    repeat (6) begin
      @(posedge clk_i);
      chk("b_switch", 32'(b_in_i), 32'h1234);
    end
  endtask : t_fwd
  task t_back;
    setup(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 16'h0, 16'hbeef);
    chk("a_bus", 32'(a_in_i), 32'hbeef);
    pulse(2'h3, 2'h3);
    rd(4'h4, 32'hbeef, `RBT_RESP_OKAY);
    rd(4'h8, 32'hbeef, `RBT_RESP_OKAY);
    setup(2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0, 16'h0);
    chk("loop", 32'({a_in_i, b_in_i}), 32'hbeefbeef);
  endtask : t_back
  task t_stored;
    setup(2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h3, 16'h0, 16'h0f0f);
    chk("a_bus", 32'(a_in_i), 32'hbeef);
    pulse(2'h0, 2'h3);
    chk("a_bus", 32'(a_in_i), 32'h0f0f);
    rd(4'h4, 32'hbeef, `RBT_RESP_OKAY);
  endtask : t_stored
  task t_cross;
    setup(2'h3, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 16'h0, 16'h0);
    chk("both", 32'({a_in_i, b_in_i}), 32'h0f0fbeef);
  endtask : t_cross
  task t_hold;
    setup(2'h0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0, 16'h0);
    chk("held", 32'({a_in_i, b_in_i}), 32'h0f0fbeef);
    chk("a_keep", 32'(a_keep_o), 32'h0f0f);
    chk("b_keep", 32'(b_keep_o), 32'hbeef);
  endtask : t_hold
  task t_regs;
    wr(4'h0, 32'h1, `RBT_RESP_OKAY);
    rd(4'h0, 32'h1, `RBT_RESP_OKAY);
    wr(4'h4, 32'hffff, `RBT_RESP_OKAY);
    rd(4'h4, 32'hbeef, `RBT_RESP_OKAY);
    wr(4'h2, 32'h0, `RBT_RESP_SLVERR);
    rd(4'h2, 32'h0, `RBT_RESP_SLVERR);
    setup(2'h1, 2'h3, 2'h0, 2'h0, 2'h3, 2'h0, 16'h6699, 16'h0);
    chk("gang", 32'({b_oe_n_o, b_in_i}), 32'h6699);
  endtask : t_regs
  initial begin
    rst_n_i = 1'b0;
    {a_drv, b_drv, a_den, b_den, a_to_b_drive_en_i, a_capture_clk_i, b_capture_clk_i} = '0;
    {b_port_source_sel_i, a_port_source_sel_i, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    b_to_a_drive_en_n_i = 2'h3;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_isolate();
    t_fwd();
    t_back();
    t_stored();
    t_cross();
    t_hold();
    t_regs();
    close_out();
  end
endmodule : tb_registered_bus_transceiver
